// [charger_i2c_slave_port_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module charger_i2c_slave_port_tb_top;
  logic       clk_in;
  logic       rstn_in;
  logic       req;
  logic       rd;
  logic [6:0] dev;
  logic [7:0] ra;
  logic [7:0] wd;
  logic       busy;
  logic       done;
  logic       nack;
  logic       hs;
  logic       adr;
  logic       stb;
  logic       hs_seen;
  logic [7:0] rdat;
  logic [7:0] wdat;
  logic [7:0] sdat;
  logic [7:0] st_d;
  logic [7:0] shf;
  logic [2:0] wa;
  logic [2:0] raddr;
  logic [2:0] st_a;
  logic [7:0] regs [8];
  int         n_fail;
  int         comparisons;
  int         n_stb;
  int         nbit;

  chgi2c_bus_if bus ();
  chgi2c_slave #(.REG_COUNT(5)) u_chgi2c_slave (.clk_in(clk_in), .rstn_in(rstn_in), .bus(bus),
    .wr_addr_out(wa), .wr_data_out(wdat), .wr_strobe_out(stb), .rd_addr_out(raddr),
    .rd_data_in(sdat), .hs_mode_out(hs), .addressed_out(adr));
  // Small divider keeps the run short
  chgi2c_master #(.DIV(7)) u_chgi2c_master (.clk_in(clk_in), .rstn_in(rstn_in), .bus(bus),
    .req_in(req), .read_in(rd), .dev_addr_in(dev), .reg_addr_in(ra), .data_in(wd),
    .busy_out(busy), .done_out(done), .nack_out(nack), .data_out(rdat));
  chgi2c_bus_sva u_chgi2c_bus_sva (.clk_in(clk_in), .rstn_in(rstn_in), .scl(bus.scl), .sda(bus.sda),
    .scl_out(bus.scl_out), .scl_oe_n(bus.scl_oe_n), .sda_m_out(bus.sda_m_out),
    .sda_m_oe_n(bus.sda_m_oe_n), .sda_s_out(bus.sda_s_out), .sda_s_oe_n(bus.sda_s_oe_n));

  assign sdat = regs[raddr];

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    if (stb === 1'b1)
    begin
      n_stb++;
      st_a = wa;
      st_d = wdat;
      regs[wa] = wdat;
    end
    if (hs === 1'b1)
      hs_seen = 1'b1;
  end

  // First byte after a start, as seen on the wire
  always @(negedge bus.sda)
    if (bus.scl === 1'b1)
      nbit = 0;
  always @(posedge bus.scl)
    if (nbit < 8)
    begin
      shf = {shf[6:0], bus.sda};
      nbit++;
    end

  task automatic check_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit

  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check_byte

  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic cmd(input logic r, input logic [6:0] d, input logic [7:0] a, input logic [7:0] v);
    int i;
    @(negedge clk_in);
    n_stb = 0;
    hs_seen = 1'b0;
    req = 1'b1;
    rd = r;
    dev = d;
    ra = a;
    wd = v;
    @(negedge clk_in);
    req = 1'b0;
    for (i = 0; i < 3000 && done !== 1'b1; i++)
      @(negedge clk_in);
    if (i == 3000)
    begin
      n_fail++;
      give_verdict();
    end
    repeat (20) @(negedge clk_in);
  endtask : cmd

  task automatic t_wr_rd();
    logic [7:0] v;
    for (int k = 0; k < 5; k++)
    begin
      v = 8'h5A ^ 8'(k * 17);
      cmd(1'b0, 7'h6B, 8'(k), v);
      check_bit("wr_nack", 1'b0, nack);
      check_byte("addr_byte", 8'hD6, shf);
      check_byte("stb_count", 8'h01, 8'(n_stb));
      check_byte("wr_addr", 8'(k), {5'h00, st_a});
      check_byte("wr_data", v, st_d);
      cmd(1'b1, 7'h6B, 8'(k), 8'h00);
      check_byte("addr_byte", 8'hD7, shf);
      check_byte("rd_data", v, rdat);
      check_bit("idle_sda", 1'b1, bus.sda);
      check_bit("adr_idle", 1'b0, adr);
      check_bit("busy_idle", 1'b0, busy);
    end
  endtask : t_wr_rd

  task automatic t_refuse();
    logic [6:0] da [3] = '{7'h6A, 7'h6B, 7'h6B};
    logic [7:0] rg [3] = '{8'h02, 8'h05, 8'h08};
    for (int k = 0; k < 3; k++)
    begin
      cmd(1'b0, da[k], rg[k], 8'h77);
      check_bit("bad_nack", 1'b1, nack);
      check_byte("bad_stb", 8'h00, 8'(n_stb));
    end
  endtask : t_refuse

  task automatic t_mcode();
    cmd(1'b0, 7'h04, 8'h00, 8'h00);
    check_bit("mc_nack", 1'b1, nack);
    check_bit("hs_seen", 1'b1, hs_seen);
    check_bit("hs_after_stop", 1'b0, hs);
    check_byte("mc_stb", 8'h00, 8'(n_stb));
  endtask : t_mcode

  task automatic t_abort();
    @(negedge clk_in);
    req = 1'b1;
    ra = 8'h01;
    rd = 1'b0;
    dev = 7'h6B;
    @(negedge clk_in);
    req = 1'b0;
    repeat (150) @(negedge clk_in);
    rstn_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rstn_in = 1'b1;
    repeat (20) @(negedge clk_in);
    check_bit("abort_sda", 1'b1, bus.sda);
    check_bit("abort_scl", 1'b1, bus.scl);
    cmd(1'b0, 7'h6B, 8'h01, 8'hC3);
    check_bit("after_nack", 1'b0, nack);
    check_byte("after_data", 8'hC3, st_d);
  endtask : t_abort

  initial
  begin
    rstn_in = 1'b0;
    req = 1'b0;
    rd = 1'b0;
    dev = 7'h00;
    ra = 8'h00;
    wd = 8'h00;
    n_fail = 0;
    comparisons = 0;
    nbit = 8;
    for (int i = 0; i < 8; i++)
      regs[i] = 8'h00;
    repeat (10) @(negedge clk_in);
    rstn_in = 1'b1;
    t_wr_rd();
    t_refuse();
    t_mcode();
    t_abort();
    give_verdict();
  end
endmodule : charger_i2c_slave_port_tb_top
`default_nettype wire

// [chgi2c_bus_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface chgi2c_bus_if;
  logic scl_out;
  logic scl_oe_n;
  logic sda_m_out;
  logic sda_m_oe_n;
  logic sda_s_out;
  logic sda_s_oe_n;
  wire  scl = scl_oe_n ? 1'b1 : scl_out;
  wire  sda = (sda_m_oe_n ? 1'b1 : sda_m_out) & (sda_s_oe_n ? 1'b1 : sda_s_out);
  modport slave (input scl, input sda, output sda_s_out, output sda_s_oe_n);
  modport master (input scl, input sda, output scl_out, output scl_oe_n, output sda_m_out, output sda_m_oe_n);
endinterface : chgi2c_bus_if
`default_nettype wire

// [chgi2c_bus_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module chgi2c_bus_sva (
  // System
  input wire logic clk_in,
  input wire logic rstn_in,
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_m_out,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_out,
  input wire logic sda_s_oe_n
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  a_slave_pull_low: assert property (!sda_s_oe_n |-> !sda_s_out)
    else $error("slave drives sda high");
  a_master_pull_low: assert property ((scl_oe_n || !scl_out) && (sda_m_oe_n || !sda_m_out))
    else $error("master drives a line high");
  a_scl_high_len: assert property ($rose(scl) |-> scl[*6])
    else $error("scl high phase too short");
  a_scl_low_len: assert property ($fell(scl) |-> !scl[*6])
    else $error("scl low phase too short");
  a_slave_hold_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe_n))
    else $error("slave changed sda while scl high");
  a_one_driver: assert property (!sda_m_oe_n && scl |-> sda_s_oe_n)
    else $error("slave drives during master bit");
  a_stop_release: assert property ($rose(sda) && scl |-> ##3 sda_s_oe_n[*8])
    else $error("slave not released after stop");
  a_start_hold: assert property ($fell(sda) && scl |-> scl[*4])
    else $error("scl fell right after start");
  c_ack: cover property ($fell(sda_s_oe_n));
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
endmodule : chgi2c_bus_sva
`default_nettype wire

// [chgi2c_map.svh]
// Functional notes
// - Slave only; standard, fast, high-speed rates
// - Logic follows serial clock edges, no filtering
// - Master changes data only while clock low
// - Seven-bit address only, fixed 1101011
// - Start is data fall while clock high
// - Master makes clock, start, stop, address
// - Shift address byte, compare seven bits
// - Matching address acknowledged low ninth pulse
// - Mismatch: no acknowledge, ignore until start
// - Transmitter keeps data stable while clock high
// - Slave acknowledges every write data byte; master nacks its one read byte; slave nacks a register byte outside the map
// - Any number of nine-bit units
// - Stop is data rise while clock high
// - After stop idle until start plus address
// - Master ends aborted transfer with stop
// - Unimplemented register reads return all ones
// - Open-drain lines; pull low or release
// - Master code unacknowledged, high-speed until stop
// - Register address upper five bits zero
// - Write takes effect at acknowledge falling edge
// - Further updates: register then data bytes
`ifndef CHGI2C_MAP_SVH
`define CHGI2C_MAP_SVH
`define CHGI2C_SLAVE_ADDR   7'h6B
`define CHGI2C_MCODE_TOP    5'h01
`define CHGI2C_REG_COUNT    5
`define CHGI2C_UNIMPL_DATA  8'hFF
`define CHGI2C_LAST_BIT     3'h7
`define CHGI2C_CLK_DIV      16'd31
`endif

// [chgi2c_master.sv]
`timescale 1ns/1ns
`default_nettype none
`include "chgi2c_map.svh"
module chgi2c_master
  import chgi2c_pkg::*;
#(
  parameter int DIV = `CHGI2C_CLK_DIV
)(
  // System
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Bus
  chgi2c_bus_if.master     bus,
  // User command: write or read one register
  input  wire logic        req_in,
  input  wire logic        read_in,
  input  wire logic [6:0]  dev_addr_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  data_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             nack_out,
  output logic [7:0]       data_out
);
  // Divider counter is sixteen bits wide
  if (DIV < 2 || DIV > 65535)
  begin : g_bad_div
    $error("DIV out of range");
  end

  chgi2c_mstate_t st_reg;
  logic [15:0] div_reg;
  logic [26:0] seq_reg;   // Bits to send, MSB first
  logic [26:0] own_reg;   // 1 = master drives that bit, 0 = listens
  logic [4:0]  left_reg;
  logic [4:0]  pos_reg;
  logic        scl_lo_reg, sda_lo_reg;
  logic        rd_reg;
  logic [1:0]  sda_sync_reg;

  wire tick = div_reg == 16'(DIV);

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      sda_sync_reg <= 2'h3;
    else
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      st_reg     <= M_IDLE;
      div_reg    <= 16'h0000;
      seq_reg    <= 27'h0;
      own_reg    <= 27'h0;
      left_reg   <= 5'h00;
      pos_reg    <= 5'h00;
      scl_lo_reg <= 1'b0;
      sda_lo_reg <= 1'b0;
      rd_reg     <= 1'b0;
      done_out   <= 1'b0;
      nack_out   <= 1'b0;
      data_out   <= 8'h00;
    end
    else
    begin
      done_out <= 1'b0;
      div_reg  <= tick ? 16'h0000 : div_reg + 16'h0001;
      case (st_reg)
        M_IDLE:
          if (req_in)
          begin
            // Write: address, register byte, then data; read: address, then read byte
            rd_reg   <= read_in;
            seq_reg  <= {dev_addr_in, read_in, 1'b1, read_in ? 8'hFF : reg_addr_in, 1'b1,
                         read_in ? 8'hFF : data_in, 1'b1};
            own_reg  <= {8'hFF, 1'b0, read_in ? 8'h00 : 8'hFF, 1'b0, read_in ? 8'h00 : 8'hFF,
                         read_in ? 1'b1 : 1'b0};
            left_reg <= read_in ? 5'd18 : 5'd27;
            pos_reg  <= 5'h00;
            nack_out <= 1'b0;
            div_reg  <= 16'h0000;
            st_reg   <= M_START;
          end
        M_START:
          if (tick)
          begin
            sda_lo_reg <= 1'b1;
            st_reg     <= M_BIT_LO;
          end
        M_BIT_LO:
          if (tick)
          begin
            scl_lo_reg <= 1'b1;
            // Data moves only with the clock low
            sda_lo_reg <= own_reg[26] & ~seq_reg[26];
            st_reg     <= M_BIT_HI;
          end
        M_BIT_HI:
          if (tick)
          begin
            scl_lo_reg <= 1'b0;
            if (rd_reg && pos_reg >= 5'd9 && pos_reg < 5'd17)
              data_out <= {data_out[6:0], sda_sync_reg[1]};
            if ((pos_reg == 5'd8 || pos_reg == 5'd17 || pos_reg == 5'd26) && !own_reg[26] && sda_sync_reg[1])
              nack_out <= 1'b1;
            seq_reg  <= {seq_reg[25:0], 1'b1};
            own_reg  <= {own_reg[25:0], 1'b0};
            pos_reg  <= pos_reg + 5'h01;
            left_reg <= left_reg - 5'h01;
            st_reg   <= (left_reg == 5'h01) ? M_STOP_LO : M_BIT_LO;
          end
        M_STOP_LO:
          if (tick)
          begin
            scl_lo_reg <= 1'b1;
            sda_lo_reg <= 1'b1;
            st_reg     <= M_STOP_HI;
          end
        M_STOP_HI:
          if (tick)
          begin
            scl_lo_reg <= 1'b0;
            st_reg     <= M_DONE;
          end
        M_DONE:
          if (tick)
          begin
            sda_lo_reg <= 1'b0;
            done_out   <= 1'b1;
            st_reg     <= M_IDLE;
          end
        default:
          st_reg <= M_IDLE;
      endcase
    end
  end

  // Read sends address then reads one byte; register pointer is set by a prior write
  assign busy_out       = st_reg != M_IDLE;
  assign bus.scl_out    = 1'b0;
  assign bus.scl_oe_n   = ~scl_lo_reg;
  assign bus.sda_m_out  = 1'b0;
  assign bus.sda_m_oe_n = ~sda_lo_reg;
endmodule : chgi2c_master
`default_nettype wire

// [chgi2c_pkg.sv]
package chgi2c_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REGA, ST_WDATA, ST_RDATA, ST_IGNORE} chgi2c_state_t;
  typedef enum logic [3:0] {M_IDLE, M_START, M_BIT_LO, M_BIT_HI, M_STOP_LO, M_STOP_HI, M_DONE} chgi2c_mstate_t;
endpackage : chgi2c_pkg

// [chgi2c_slave.sv]
`timescale 1ns/1ns
`default_nettype none
`include "chgi2c_map.svh"
module chgi2c_slave
  import chgi2c_pkg::*;
#(
  parameter int REG_COUNT = `CHGI2C_REG_COUNT
)(
  // System
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Bus
  chgi2c_bus_if.slave      bus,
  // Register file
  output logic [2:0]       wr_addr_out,
  output logic [7:0]       wr_data_out,
  output logic             wr_strobe_out,
  output logic [2:0]       rd_addr_out,
  input  wire logic [7:0]  rd_data_in,
  output logic             hs_mode_out,
  output logic             addressed_out
);
  // Register index is three bits wide
  if (REG_COUNT < 1 || REG_COUNT > 8)
  begin : g_bad_count
    $error("REG_COUNT out of range");
  end

  // Two-stage sync of both lines; edges seen on the second and third stage
  logic [1:0]    scl_sync_reg, sda_sync_reg;
  logic          scl_d_reg, sda_d_reg;
  chgi2c_state_t state_reg;
  logic [2:0]    bit_cnt_reg;
  logic          ack_phase_reg;
  logic          in_ack_reg;
  logic [7:0]    shift_reg;
  logic [7:0]    tx_reg;
  logic          drive_low_reg;
  logic          ack_ok_reg;
  logic          wr_pend_reg;
  logic          master_ack_reg;

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  wire scl_s    = scl_sync_reg[1];
  wire sda_s    = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire [7:0] byte_in  = {shift_reg[6:0], sda_s};
  wire       byte_end = scl_rise & ~ack_phase_reg & (bit_cnt_reg == `CHGI2C_LAST_BIT);
  wire       addr_hit = byte_in[7:1] == `CHGI2C_SLAVE_ADDR;
  wire       mcode    = byte_in[7:3] == `CHGI2C_MCODE_TOP;
  wire       reg_ok   = (byte_in[7:3] == 5'h00) && ({1'b0, byte_in[2:0]} < 4'(REG_COUNT));

  // Read data; unknown registers answer all ones
  wire [7:0] rd_value = ({1'b0, rd_addr_out} < 4'(REG_COUNT)) ? rd_data_in : `CHGI2C_UNIMPL_DATA;

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 3'h0;
      ack_phase_reg  <= 1'b0;
      in_ack_reg     <= 1'b0;
      shift_reg      <= 8'h00;
      tx_reg         <= 8'h00;
      drive_low_reg  <= 1'b0;
      ack_ok_reg     <= 1'b0;
      wr_pend_reg    <= 1'b0;
      master_ack_reg <= 1'b0;
      wr_addr_out    <= 3'h0;
      wr_data_out    <= 8'h00;
      wr_strobe_out  <= 1'b0;
      rd_addr_out    <= 3'h0;
      hs_mode_out    <= 1'b0;
    end
    else
    begin
      wr_strobe_out <= 1'b0;
      if (stop_c)
      begin
        state_reg     <= ST_IDLE;
        drive_low_reg <= 1'b0;
        hs_mode_out   <= 1'b0;
        wr_pend_reg   <= 1'b0;
      end
      else if (start_c)
      begin
        state_reg     <= ST_ADDR;
        bit_cnt_reg   <= 3'h0;
        ack_phase_reg <= 1'b0;
        in_ack_reg    <= 1'b0;
        drive_low_reg <= 1'b0;
        wr_pend_reg   <= 1'b0;
      end
      else if (state_reg != ST_IDLE && state_reg != ST_IGNORE)
      begin
        if (scl_rise && !ack_phase_reg)
        begin
          shift_reg   <= byte_in;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
        if (scl_rise && ack_phase_reg && state_reg == ST_RDATA)
          master_ack_reg <= ~sda_s;
        if (byte_end)
        begin
          ack_phase_reg <= 1'b1;
          ack_ok_reg    <= 1'b1;
          case (state_reg)
            ST_ADDR:
            begin
              if (mcode)
              begin
                hs_mode_out <= 1'b1;
                ack_ok_reg  <= 1'b0;
              end
              else if (!addr_hit)
                ack_ok_reg <= 1'b0;
            end
            ST_REGA:
            begin
              wr_addr_out <= byte_in[2:0];
              rd_addr_out <= byte_in[2:0];
              ack_ok_reg  <= reg_ok;
            end
            ST_WDATA:
            begin
              wr_data_out <= byte_in;
              wr_pend_reg <= 1'b1;
            end
            ST_RDATA:
              ack_ok_reg <= 1'b0;
            default:
              ack_ok_reg <= 1'b0;
          endcase
        end
        if (scl_fall && ack_phase_reg && !in_ack_reg)
        begin
          // Own flag for the slot; a nack leaves the line high and cannot mark it
          in_ack_reg    <= 1'b1;
          drive_low_reg <= ack_ok_reg;
          if (state_reg == ST_RDATA)
            drive_low_reg <= 1'b0;
        end
        else if (scl_fall && ack_phase_reg)
        begin
          // Fall that ends the acknowledge slot
          ack_phase_reg <= 1'b0;
          in_ack_reg    <= 1'b0;
          drive_low_reg <= 1'b0;
          case (state_reg)
            ST_ADDR:
              if (!ack_ok_reg)
                state_reg <= ST_IGNORE;
              else if (shift_reg[0])
              begin
                state_reg <= ST_RDATA;
                tx_reg    <= rd_value;
              end
              else
                state_reg <= ST_REGA;
            ST_REGA:
              state_reg <= ack_ok_reg ? ST_WDATA : ST_IGNORE;
            ST_WDATA:
            begin
              state_reg     <= ST_REGA;
              wr_strobe_out <= wr_pend_reg;
              wr_pend_reg   <= 1'b0;
            end
            ST_RDATA:
            begin
              // No master acknowledge: stay off the line
              state_reg <= master_ack_reg ? ST_RDATA : ST_IGNORE;
              tx_reg    <= rd_value;
            end
            default:
              state_reg <= ST_IGNORE;
          endcase
        end
        else if (state_reg == ST_RDATA && !ack_phase_reg && scl_fall)
          tx_reg <= {tx_reg[6:0], 1'b1};
        else if (state_reg == ST_RDATA && !ack_phase_reg)
          drive_low_reg <= ~tx_reg[7];
      end
    end
  end

  // Only ever pull low or release
  assign bus.sda_s_out  = 1'b0;
  assign bus.sda_s_oe_n = ~drive_low_reg;
  assign addressed_out  = state_reg != ST_IDLE && state_reg != ST_IGNORE && state_reg != ST_ADDR;
endmodule : chgi2c_slave
`default_nettype wire
